/* File: hw/pwm_fault_trigger.sv */
// pwm generator counter gating and fault trigger logic, avalon-mm slave
// assumes fault and comparator inputs synchronous to clk_sys_in
// Function
// RULE_01: a disabled generator holds its counter without touching the others.
// RULE_02: an enabled generator counter advances every pwm clock.
// RULE_03: each generator keeps a high or low sense bit for each of four fault inputs.
// RULE_04: an asserted fault keeps the fault active for at least the programmed cycles.
// RULE_05: the minimum period counts pwm clocks and applies only in min period mode.
// RULE_06: fault inputs are sense adjusted then ORed over the selected sources.
// RULE_07: without extended source mode only fault input zero feeds the fault.
// RULE_08: each generator holds a four bit input mask and an eight bit comparator mask.
// RULE_09: status reads return live triggers, or latched triggers in latch mode.
// RULE_10: a set status bit means the trigger is active or was latched active.
// RULE_11: latched triggers stay set until software clears them.
// RULE_12: software reads back both selection masks of each generator.
// RULE_13: the fault interrupt stays asserted while the minimum period runs.
// RULE_14: each module fault interrupt is the OR of that generator's configured triggers.
// RULE_15: a latch clear only touches the requested bits; set wins over clear.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "pwm_fault_consts.svh"
module pwm_fault_trigger (
   input  wire logic                       clk_sys_in,
   input  wire logic                       rst_n_in,
   input  wire logic [`ADDR_WIDTH-1:0]     avs_address_in,
   input  wire logic                       avs_read_in,
   input  wire logic                       avs_write_in,
   input  wire logic [31:0]                avs_writedata_in,
   output logic      [31:0]                avs_readdata_out,
   output logic                            avs_waitrequest_out,
   input  wire logic [`FAULT_IN_COUNT-1:0] external_fault_input_in,
   input  wire logic [`CMP_TRIG_COUNT-1:0] digital_comparator_trigger_in,
   output logic      [`GEN_COUNT-1:0]      gen_fault_out,
   output logic      [63:0]                gen_counter_out,
   output logic                            irq_out
);
   localparam int NG = `GEN_COUNT;
   localparam int NF = `FAULT_IN_COUNT;
   localparam int NC = `CMP_TRIG_COUNT;

   // ==========================================================
   // state
   // ==========================================================
   pwm_fault_pkg::gen_cfg_s    cfg_ff      [NG];
   pwm_fault_pkg::gen_cfg_s    nxt_cfg     [NG];
   logic [15:0]                minper_ff   [NG];
   logic [15:0]                nxt_minper  [NG];
   logic [NF-1:0]              sel0_ff     [NG];
   logic [NF-1:0]              nxt_sel0    [NG];
   logic [NC-1:0]              sel1_ff     [NG];
   logic [NC-1:0]              nxt_sel1    [NG];
   logic [NF-1:0]              lat0_ff     [NG];
   logic [NF-1:0]              nxt_lat0    [NG];
   logic [NC-1:0]              lat1_ff     [NG];
   logic [NC-1:0]              nxt_lat1    [NG];
   logic [15:0]                cnt_ff      [NG];
   logic [15:0]                nxt_cnt     [NG];
   logic [15:0]                hold_ff     [NG];
   logic [15:0]                nxt_hold    [NG];
   logic [NG-1:0]              fault_ff;
   logic [NG-1:0]              nxt_fault;
   logic [NG-1:0]              ist_ff;
   logic [NG-1:0]              nxt_ist;
   logic [NG-1:0]              imask_ff;
   logic [NG-1:0]              nxt_imask;
   logic                       irq_ff;
   logic                       nxt_irq;
   logic [31:0]                rdata_ff;
   logic [31:0]                nxt_rdata;
   pwm_fault_pkg::bus_state_e  bus_ff;
   pwm_fault_pkg::bus_state_e  nxt_bus;
   logic                       wait_ff;
   logic                       nxt_wait;
   pwm_fault_pkg::bus_req_s    req;
   logic [NF-1:0]              adj_in      [NG];
   logic [NG-1:0]              raw_fault;

   // sense adjust: a set low-sense bit inverts the pin
   function automatic logic [NF-1:0] sense_adjust(input logic [NF-1:0] pins,
                                                  input logic [NF-1:0] low);
      sense_adjust = pins ^ low;
   endfunction : sense_adjust

   assign req = '{address: avs_address_in, read: avs_read_in,
                  write: avs_write_in, writedata: avs_writedata_in};

   // ==========================================================
   // fault source combining
   // ==========================================================
   always_comb
   begin
      for (int g = 0; g < NG; g++)
      begin
         adj_in[g] = sense_adjust(external_fault_input_in, cfg_ff[g].input_asserted_low); // [RULE_03] [RULE_06]
         if (cfg_ff[g].extended_fault_source_mode)
         begin
            raw_fault[g] = |(adj_in[g] & sel0_ff[g])
                         | |(digital_comparator_trigger_in & sel1_ff[g]); // [RULE_06] [RULE_08]
         end
         else
         begin
            raw_fault[g] = adj_in[g][0]; // [RULE_07]
         end
      end
   end

   // ==========================================================
   // bus, counters, latches, hold timers
   // ==========================================================
   always_comb
   begin
      logic [2:0]  gi;
      logic [7:0]  off;
      logic        in_gen;
      logic        take;
      logic        wr;
      logic        rd;
      logic [31:0] d;
      gi     = req.address[7:5];
      off    = {3'b000, req.address[4:0]};
      in_gen = (gi < 3'(NG));
      take   = (req.write || req.read) && (bus_ff == pwm_fault_pkg::BUS_IDLE);
      wr     = req.write && (bus_ff == pwm_fault_pkg::BUS_DONE);
      rd     = req.read && (bus_ff == pwm_fault_pkg::BUS_IDLE);
      d      = req.writedata;
      nxt_bus   = take ? pwm_fault_pkg::BUS_DONE : pwm_fault_pkg::BUS_IDLE;
      nxt_wait  = !take;
      nxt_rdata = rdata_ff;
      nxt_imask = imask_ff;
      nxt_ist   = ist_ff & ~((wr && req.address == `OFF_INT_STATUS) ? d[NG-1:0] : '0);
      nxt_ist   = nxt_ist | raw_fault | fault_ff; // [RULE_15] [RULE_13]
      if (wr && req.address == `OFF_INT_MASK)
      begin
         nxt_imask = d[NG-1:0];
      end
      for (int g = 0; g < NG; g++)
      begin
         nxt_cfg[g]    = cfg_ff[g];
         nxt_minper[g] = minper_ff[g];
         nxt_sel0[g]   = sel0_ff[g];
         nxt_sel1[g]   = sel1_ff[g];
         nxt_cnt[g]    = cfg_ff[g].enable ? cnt_ff[g] + 16'h0001 : cnt_ff[g]; // [RULE_01] [RULE_02]
         nxt_lat0[g]   = lat0_ff[g];
         nxt_lat1[g]   = lat1_ff[g];
         if (wr && in_gen && gi == 3'(g))
         begin
            case (off)
               `OFF_GEN_CTRL:    nxt_cfg[g]    = d[7:0];
               `OFF_MIN_PERIOD:  nxt_minper[g] = d[15:0];
               `OFF_SEL_GROUP0:  nxt_sel0[g]   = d[NF-1:0]; // [RULE_08]
               `OFF_SEL_GROUP1:  nxt_sel1[g]   = d[NC-1:0]; // [RULE_08]
               `OFF_STAT_GROUP0: nxt_lat0[g]   = lat0_ff[g] & ~d[NF-1:0]; // [RULE_15]
               `OFF_STAT_GROUP1: nxt_lat1[g]   = lat1_ff[g] & ~d[NC-1:0]; // [RULE_15]
               `OFF_COUNTER:     nxt_cnt[g]    = d[15:0];
               default:          nxt_cnt[g]    = nxt_cnt[g];
            endcase
         end
         // set wins over clear
         if (cfg_ff[g].latch_mode)
         begin
            nxt_lat0[g] = nxt_lat0[g] | adj_in[g]; // [RULE_11] [RULE_15]
            nxt_lat1[g] = nxt_lat1[g] | digital_comparator_trigger_in; // [RULE_11]
         end
         // minimum period hold timer
         if (raw_fault[g] && cfg_ff[g].min_fault_period_mode)
         begin
            nxt_hold[g] = minper_ff[g]; // [RULE_04] [RULE_05]
         end
         else if (hold_ff[g] != 16'h0000 && cfg_ff[g].min_fault_period_mode)
         begin
            nxt_hold[g] = hold_ff[g] - 16'h0001; // [RULE_05]
         end
         else
         begin
            nxt_hold[g] = 16'h0000;
         end
         nxt_fault[g] = raw_fault[g] || (nxt_hold[g] != 16'h0000); // [RULE_04] [RULE_14]
      end
      if (rd)
      begin
         nxt_rdata = 32'h0000_0000;
         if (in_gen)
         begin
            case (off)
               `OFF_GEN_CTRL:    nxt_rdata = {24'h00_0000, cfg_ff[gi[1:0]]};
               `OFF_MIN_PERIOD:  nxt_rdata = {16'h0000, minper_ff[gi[1:0]]};
               `OFF_SEL_GROUP0:  nxt_rdata = {28'h000_0000, sel0_ff[gi[1:0]]}; // [RULE_12]
               `OFF_SEL_GROUP1:  nxt_rdata = {24'h00_0000, sel1_ff[gi[1:0]]}; // [RULE_12]
               `OFF_STAT_GROUP0: nxt_rdata = {28'h000_0000, cfg_ff[gi[1:0]].latch_mode
                                    ? lat0_ff[gi[1:0]] : adj_in[gi[1:0]]}; // [RULE_09] [RULE_10]
               `OFF_STAT_GROUP1: nxt_rdata = {24'h00_0000, cfg_ff[gi[1:0]].latch_mode
                                    ? lat1_ff[gi[1:0]] : digital_comparator_trigger_in}; // [RULE_09]
               `OFF_COUNTER:     nxt_rdata = {16'h0000, cnt_ff[gi[1:0]]};
               default:          nxt_rdata = 32'h0000_0000;
            endcase
         end
         else if (req.address == `OFF_INT_STATUS)
         begin
            nxt_rdata = {28'h000_0000, ist_ff};
         end
         else if (req.address == `OFF_INT_MASK)
         begin
            nxt_rdata = {28'h000_0000, imask_ff};
         end
         else if (req.address == `OFF_FAULT_LIVE)
         begin
            nxt_rdata = {28'h000_0000, fault_ff};
         end
      end
      nxt_irq = |(nxt_ist & nxt_imask); // [RULE_13]
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int g = 0; g < NG; g++)
         begin
            cfg_ff[g]    <= '0;
            minper_ff[g] <= 16'h0000;
            sel0_ff[g]   <= `SEL0_RESET;
            sel1_ff[g]   <= 8'h00;
            lat0_ff[g]   <= 4'h0;
            lat1_ff[g]   <= 8'h00;
            cnt_ff[g]    <= 16'h0000;
            hold_ff[g]   <= 16'h0000;
         end
         fault_ff <= 4'h0;
         ist_ff   <= 4'h0;
         imask_ff <= 4'h0;
         irq_ff   <= 1'b0;
         rdata_ff <= `RESET_WORD;
         bus_ff   <= pwm_fault_pkg::BUS_IDLE;
         wait_ff  <= 1'b1;
      end
      else
      begin
         cfg_ff    <= nxt_cfg;
         minper_ff <= nxt_minper;
         sel0_ff   <= nxt_sel0;
         sel1_ff   <= nxt_sel1;
         lat0_ff   <= nxt_lat0;
         lat1_ff   <= nxt_lat1;
         cnt_ff    <= nxt_cnt;
         hold_ff   <= nxt_hold;
         fault_ff  <= nxt_fault;
         ist_ff    <= nxt_ist;
         imask_ff  <= nxt_imask;
         irq_ff    <= nxt_irq;
         rdata_ff  <= nxt_rdata;
         bus_ff    <= nxt_bus;
         wait_ff   <= nxt_wait;
      end
   end

   assign avs_readdata_out    = rdata_ff;
   assign avs_waitrequest_out = wait_ff;
   assign gen_fault_out       = fault_ff;
   assign gen_counter_out     = {cnt_ff[3], cnt_ff[2], cnt_ff[1], cnt_ff[0]};
   assign irq_out             = irq_ff;

   // ==========================================================
   // checks
   // ==========================================================
   hold_counter_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_01]
      !cfg_ff[0].enable && !(req.write && bus_ff == pwm_fault_pkg::BUS_DONE)
      |=> $stable(cnt_ff[0])) else $error("disabled counter moved");
   run_counter_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_02]
      cfg_ff[2].enable && !req.write |=> cnt_ff[2] == $past(cnt_ff[2]) + 16'h0001)
      else $error("enabled counter stalled");
   legacy_src_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_07]
      !cfg_ff[0].extended_fault_source_mode && !cfg_ff[0].min_fault_period_mode
      |=> fault_ff[0] == ($past(external_fault_input_in[0])
                          ^ $past(cfg_ff[0].input_asserted_low[0])))
      else $error("legacy fault source wrong");
   or_sources_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_06]
      cfg_ff[2].extended_fault_source_mode && |(digital_comparator_trigger_in & sel1_ff[2])
      |=> fault_ff[2]) else $error("selected trigger ignored");
   min_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_04]
      raw_fault[3] && cfg_ff[3].min_fault_period_mode && minper_ff[3] > 16'h0002
      && !req.write |=> fault_ff[3] [*2]) else $error("fault released early");
   latch_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_11]
      cfg_ff[1].latch_mode && lat0_ff[1][2] && !req.write |=> lat0_ff[1][2])
      else $error("latched trigger lost");
   irq_level_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_13]
      fault_ff[3] && imask_ff[3] && !req.write |=> irq_out) else $error("fault irq not raised");
   bus_answer_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // bus answer timing of the locally decided Avalon-MM interface
      (req.read || req.write) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("bus answer late");
   live_status_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_09]
      req.read && bus_ff == pwm_fault_pkg::BUS_IDLE && req.address == `OFF_STAT_GROUP1
      && !cfg_ff[0].latch_mode |=> avs_readdata_out == {24'h00_0000, $past(digital_comparator_trigger_in)});
   mask_readback_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_12]
      req.read && bus_ff == pwm_fault_pkg::BUS_IDLE && req.address[7:5] == 3'd2
      && req.address[4:0] == 5'(`OFF_SEL_GROUP1) |=> avs_readdata_out[7:0] == $past(sel1_ff[2]));
   latch_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_15]
      req.write && bus_ff == pwm_fault_pkg::BUS_DONE && req.address[7:5] == 3'd1
      && req.address[4:0] == 5'(`OFF_STAT_GROUP0)
      |=> ($past(lat0_ff[1]) & ~$past(req.writedata[3:0]) & ~lat0_ff[1]) == 4'h0)
      else $error("unselected latch bit cleared");
   latch_capture_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_11]
      cfg_ff[1].latch_mode && adj_in[1][0] |=> lat0_ff[1][0])
      else $error("active trigger not latched");
   sense_low_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_03]
      cfg_ff[1].extended_fault_source_mode && sel0_ff[1][0] && cfg_ff[1].input_asserted_low[0]
      && !external_fault_input_in[0] |=> fault_ff[1]) else $error("low sense fault missed");
   min_off_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_05]
      !cfg_ff[3].min_fault_period_mode |=> fault_ff[3] == $past(raw_fault[3]))
      else $error("fault held without min period mode");
   int_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE_14]
      raw_fault[2] |=> ist_ff[2])
      else $error("fault interrupt status not set");
endmodule : pwm_fault_trigger

/* File: hw/pwm_fault_consts.svh */
// constants for the pwm gating and fault trigger block
// assumes word-aligned avalon byte addressing
`ifndef PWM_FAULT_CONSTS_SVH
`define PWM_FAULT_CONSTS_SVH
`define GEN_COUNT        4
`define FAULT_IN_COUNT   4
`define CMP_TRIG_COUNT   8
`define ADDR_WIDTH       8
// per generator block of 8 words, stride 0x20
`define GEN_STRIDE_SHIFT 5
`define OFF_GEN_CTRL     8'h00
`define OFF_MIN_PERIOD   8'h04
`define OFF_SEL_GROUP0   8'h08
`define OFF_SEL_GROUP1   8'h0C
`define OFF_STAT_GROUP0  8'h10
`define OFF_STAT_GROUP1  8'h14
`define OFF_COUNTER      8'h18
`define OFF_INT_STATUS   8'h80
`define OFF_INT_MASK     8'h84
`define OFF_FAULT_LIVE   8'h88
// control word fields
`define CTRL_ENABLE_BIT  0
`define CTRL_MINPER_BIT  1
`define CTRL_EXTSRC_BIT  2
`define CTRL_LATCH_BIT   3
`define CTRL_SENSE_LSB   4
`define RESET_WORD       32'h0000_0000
`define SEL0_RESET       4'h1
`endif

/* File: hw/pwm_fault_pkg.sv */
// types shared by the pwm gating and fault trigger block
// assumes the constants header is included first
`include "pwm_fault_consts.svh"
package pwm_fault_pkg;
   // field order matches the control word, msb first
   typedef struct packed {
      logic [`FAULT_IN_COUNT-1:0] input_asserted_low;
      logic                       latch_mode;
      logic                       extended_fault_source_mode;
      logic                       min_fault_period_mode;
      logic                       enable;
   } gen_cfg_s;
   typedef struct packed {
      logic [`ADDR_WIDTH-1:0] address;
      logic                   read;
      logic                   write;
      logic [31:0]            writedata;
   } bus_req_s;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_DONE = 2'b01
   } bus_state_e;
endpackage : pwm_fault_pkg

/* File: verification/fault_source_model.sv */
// fault source model: external fault pins and comparator trigger lines
// assumes the bench commands the levels, one clock ahead of the pins
`timescale 1ns/1ps
module fault_source_model (
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   input  wire logic [3:0] fault_cmd_in,
   input  wire logic [7:0] cmp_cmd_in,
   output logic      [3:0] fault_pins_out,
   output logic      [7:0] cmp_pins_out
);
   //==========================================
   // pins move just after the edge, synchronous sources
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         fault_pins_out <= 4'h0;
         cmp_pins_out   <= 8'h00;
      end
      else
      begin
         fault_pins_out <= fault_cmd_in;
         cmp_pins_out   <= cmp_cmd_in;
      end
   end
endmodule : fault_source_model

/* File: verification/testbench.sv */
// self-checking bench for the pwm gating and fault trigger block
// assumes the fault source model drives the fault and comparator pins
`timescale 1ns/1ps
module testbench;
   logic        clk_sys_in;
   logic        rst_n_in;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata_out;
   logic        avs_waitrequest_out;
   logic [3:0]  fault_cmd;
   logic [7:0]  cmp_cmd;
   logic [3:0]  fault_pins;
   logic [7:0]  cmp_pins;
   logic [3:0]  gen_fault_out;
   logic [63:0] gen_counter_out;
   logic        irq_out;
   logic [31:0] exp_q[$];
   int          num_errors = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [15:0] r;
   logic [15:0] c0;
   logic [7:0]  m;
   //==========================================
   // clock, model and design
   initial
   begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   fault_source_model fault_source_model_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .fault_cmd_in(fault_cmd), .cmp_cmd_in(cmp_cmd), .fault_pins_out(fault_pins),
      .cmp_pins_out(cmp_pins));
   pwm_fault_trigger pwm_fault_trigger_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
      .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .external_fault_input_in(fault_pins),
      .digital_comparator_trigger_in(cmp_pins), .gen_fault_out(gen_fault_out),
      .gen_counter_out(gen_counter_out), .irq_out(irq_out));
   //==========================================
   // checks, bus tasks, timeout
   task automatic end_of_test();
      if (num_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] e, input logic [31:0] a);
      checked = checked + 1;
      if (a !== e)
      begin
         num_errors = num_errors + 1;
         $display("mismatch at %0t: expected %h got %h", $time, e, a);
      end
   endtask : chk
   task automatic chk1(input logic e, input logic a);
      chk({31'h0, e}, {31'h0, a});
   endtask : chk1
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= ~w;
      avs_writedata <= d;
      do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk_sys_in);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(a, 1'b0, 32'h0000_0000);
   endtask : rd
   task automatic pause(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : pause
   // read data taken at the edge where waitrequest is seen low
   always @(posedge clk_sys_in)
      if (avs_read === 1'b1 && avs_waitrequest_out === 1'b0)
         chk(exp_q.pop_front(), avs_readdata_out);
   always @(posedge clk_sys_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors = num_errors + 1;
         end_of_test();
      end
   end
   //==========================================
   // main sequence
   initial
   begin
      rst_n_in      = 1'b0;
      avs_address   = 8'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0000_0000;
      fault_cmd     = 4'h0;
      cmp_cmd       = 8'h00;
      r = 16'($urandom(32'h862e));
      m = {r[7:1], 1'b1};
      pause(2);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      rd(8'h00, 32'h0000_0000);
      rd(8'h08, 32'h0000_0001);
      rd(8'h2C, 32'h0000_0000);
      rd(8'hFC, 32'h0000_0000);
      wr(8'h38, {16'h0000, r});
      wr(8'h40, 32'h0000_0001);
      pause(5);
      rd(8'h38, {16'h0000, r});
      c0 = gen_counter_out[47:32];
      pause(10);
      chk({16'h0000, c0 + 16'd10}, {16'h0000, gen_counter_out[47:32]});
      wr(8'h08, 32'h0000_0002);
      fault_cmd <= 4'h2;
      pause(4);
      rd(8'h88, 32'h0000_0000);
      fault_cmd <= 4'h1;
      pause(4);
      rd(8'h88, 32'h0000_000F);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h20, 32'h0000_0004 | (32'h0000_0010 << i));
         wr(8'h28, 32'h0000_0001 << i);
         fault_cmd <= ~(4'h1 << i);
         pause(4);
         chk1(1'b1, gen_fault_out[1]);
         fault_cmd <= 4'hF;
         pause(4);
         chk1(1'b0, gen_fault_out[1]);
      end
      wr(8'h40, 32'h0000_0005);
      wr(8'h48, 32'h0000_0000);
      wr(8'h4C, {24'h0, m});
      rd(8'h4C, {24'h0, m});
      fault_cmd <= 4'h0;
      cmp_cmd   <= 8'h01;
      pause(4);
      chk1(1'b1, gen_fault_out[2]);
      cmp_cmd <= ~m;
      pause(4);
      chk1(1'b0, gen_fault_out[2]);
      rd(8'h14, {24'h0, ~m});
      wr(8'h20, 32'h0000_000C);
      fault_cmd <= 4'h5;
      @(posedge clk_sys_in);
      fault_cmd <= 4'h0;
      pause(4);
      rd(8'h30, 32'h0000_0005);
      wr(8'h30, 32'h0000_0001);
      rd(8'h30, 32'h0000_0004);
      wr(8'h30, 32'h0000_0004);
      rd(8'h30, 32'h0000_0000);
      fault_cmd <= 4'h6;
      pause(4);
      rd(8'h10, 32'h0000_0006);
      wr(8'h84, 32'h0000_0008);
      wr(8'h64, 32'h0000_0014);
      wr(8'h60, 32'h0000_0002);
      wr(8'h80, 32'h0000_000F);
      rd(8'h80, 32'h0000_0000);
      fault_cmd <= 4'h1;
      @(posedge clk_sys_in);
      fault_cmd <= 4'h0;
      pause(4);
      chk1(1'b1, gen_fault_out[3]);
      wr(8'h80, 32'h0000_0008);
      chk1(1'b1, irq_out);
      pause(8);
      chk1(1'b1, gen_fault_out[3]);
      pause(20);
      chk1(1'b0, gen_fault_out[3]);
      wr(8'h80, 32'h0000_0008);
      pause(2);
      chk1(1'b0, irq_out);
      wr(8'h60, 32'h0000_0000);
      wr(8'h84, 32'h0000_0000);
      fault_cmd <= 4'h1;
      @(posedge clk_sys_in);
      fault_cmd <= 4'h0;
      pause(4);
      chk1(1'b0, gen_fault_out[3]);
      chk1(1'b0, irq_out);
      rd(8'h80, 32'h0000_0009);
      pause(2);
      end_of_test();
   end
endmodule : testbench
